// *** rtl/interrupt_flag_enable_bank.sv ***
// top of the interrupt flag and enable bank: four flag registers, one enable
// register, a plain register port and the pending vector toward the cpu.
// assumes peripherals pulse their event lines on the system clock, and that the
// flag word matching enable register zero arrives from outside on that clock.
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
module interrupt_flag_enable_bank #(
  parameter int ADDR_W = irq_bank_pkg::ADDR_W_DEF,
  parameter bit HAS_CAN = 1'b1,
  parameter bit HAS_DAC = 1'b1
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_ce,
  // register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [irq_bank_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [irq_bank_pkg::DATA_W-1:0] o_rdata,
  // peripheral event pulses, one bit per flag position
  input wire logic [irq_bank_pkg::DATA_W-1:0] i_evt_flag_one,
  input wire logic [irq_bank_pkg::DATA_W-1:0] i_evt_flag_two,
  input wire logic [irq_bank_pkg::DATA_W-1:0] i_evt_flag_three,
  input wire logic [irq_bank_pkg::DATA_W-1:0] i_evt_flag_four,
  // flags that pair with enable register zero
  input wire logic [irq_bank_pkg::DATA_W-1:0] i_flag_zero,
  // register contents toward the cpu interrupt logic
  output logic [irq_bank_pkg::DATA_W-1:0] o_flag_one,
  output logic [irq_bank_pkg::DATA_W-1:0] o_flag_two,
  output logic [irq_bank_pkg::DATA_W-1:0] o_flag_three,
  output logic [irq_bank_pkg::DATA_W-1:0] o_flag_four,
  output logic [irq_bank_pkg::DATA_W-1:0] o_en_zero,
  // flag and enable both set, per source
  output logic [irq_bank_pkg::DATA_W-1:0] o_pend_zero
);
  import irq_bank_pkg::*;

  // the index decode compares against four-bit constants
  if (ADDR_W < 3 || ADDR_W > 16) begin : g_addr_check
    $error("ADDR_W must lie between 3 and 16");
  end

  // variant masks: absent peripherals leave their bits unimplemented
  localparam logic [15:0] VAR_MASK_TWO =
    HAS_CAN ? MASK_FLAG_TWO : (MASK_FLAG_TWO & ~CAN_BITS_TWO);
  localparam logic [15:0] VAR_MASK_FOUR_CAN =
    HAS_CAN ? MASK_FLAG_FOUR : (MASK_FLAG_FOUR & ~CAN_BITS_FOUR);
  localparam logic [15:0] VAR_MASK_FOUR =
    HAS_DAC ? VAR_MASK_FOUR_CAN : (VAR_MASK_FOUR_CAN & ~DAC_BITS_FOUR);

  // index widened to the port width for compares
  localparam logic [ADDR_W-1:0] IDX_ONE = ADDR_W'(OFS_FLAG_ONE);
  localparam logic [ADDR_W-1:0] IDX_TWO = ADDR_W'(OFS_FLAG_TWO);
  localparam logic [ADDR_W-1:0] IDX_THREE = ADDR_W'(OFS_FLAG_THREE);
  localparam logic [ADDR_W-1:0] IDX_FOUR = ADDR_W'(OFS_FLAG_FOUR);
  localparam logic [ADDR_W-1:0] IDX_EN = ADDR_W'(OFS_EN_ZERO);

  // write strobes per register
  logic wr_one; // write to flag register one
  logic wr_two; // write to flag register two
  logic wr_three; // write to flag register three
  logic wr_four; // write to flag register four
  logic wr_en; // write to enable register zero

  // current register words
  logic [15:0] flag_one_q;
  logic [15:0] flag_two_q;
  logic [15:0] flag_three_q;
  logic [15:0] flag_four_q;
  logic [15:0] en_zero_q;

  // read path and pending vector state
  logic [15:0] rdata_r; // read answer, valid the cycle after the strobe
  logic [15:0] rdata_nxt;
  logic [15:0] pend_r; // registered pending vector
  logic [15:0] pend_nxt;

  // decode writes; a write to an unmapped index is dropped silently
  always_comb begin
    wr_one = i_wr && (i_addr == IDX_ONE);
    wr_two = i_wr && (i_addr == IDX_TWO);
    wr_three = i_wr && (i_addr == IDX_THREE);
    wr_four = i_wr && (i_addr == IDX_FOUR);
    wr_en = i_wr && (i_addr == IDX_EN);
  end

  // flag register one: comparator and i2c requests
  flag_bank_reg #(
    .IMPL_MASK(MASK_FLAG_ONE)
  ) u_flag_one (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_wr(wr_one),
    .i_wdata(i_wdata),
    .i_evt(i_evt_flag_one),
    .o_q(flag_one_q)
  );

  // flag register two: dma 4/3, parallel port, can, spi two
  flag_bank_reg #(
    .IMPL_MASK(VAR_MASK_TWO)
  ) u_flag_two (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_wr(wr_two),
    .i_wdata(i_wdata),
    .i_evt(i_evt_flag_two),
    .o_q(flag_two_q)
  );

  // flag register three: calendar, dma 5, audio interface
  flag_bank_reg #(
    .IMPL_MASK(MASK_FLAG_THREE)
  ) u_flag_three (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_wr(wr_three),
    .i_wdata(i_wdata),
    .i_evt(i_evt_flag_three),
    .o_q(flag_three_q)
  );

  // flag register four: dac, can tx, dma 7/6, checksum, serial errors
  flag_bank_reg #(
    .IMPL_MASK(VAR_MASK_FOUR)
  ) u_flag_four (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_wr(wr_four),
    .i_wdata(i_wdata),
    .i_evt(i_evt_flag_four),
    .o_q(flag_four_q)
  );

  // enable register zero: no hardware source ever sets these bits
  flag_bank_reg #(
    .IMPL_MASK(MASK_EN_ZERO)
  ) u_en_zero (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_wr(wr_en),
    .i_wdata(i_wdata),
    .i_evt(16'h0000),
    .o_q(en_zero_q)
  );

  // read mux; unimplemented bits already read zero from the masked registers
  always_comb begin
    rdata_nxt = 16'h0000; // unmapped index and idle cycles answer zero
    if (i_rd) begin
      unique case (i_addr)
        IDX_ONE: begin
          rdata_nxt = flag_one_q;
        end
        IDX_TWO: begin
          rdata_nxt = flag_two_q;
        end
        IDX_THREE: begin
          rdata_nxt = flag_three_q;
        end
        IDX_FOUR: begin
          rdata_nxt = flag_four_q;
        end
        IDX_EN: begin
          rdata_nxt = en_zero_q;
        end
        default: begin
          rdata_nxt = 16'h0000;
        end
      endcase
    end
  end

  // pending: a source asks the cpu only with flag and enable both set;
  // registered, so it trails the flag by one cycle
  always_comb begin
    pend_nxt = i_flag_zero & en_zero_q;
  end

  // read data and pending vector registers; read data hold zero in every enabled cycle
  // outside the answer cycle so a stale word is never mistaken for an answer
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      rdata_r <= RESET_VAL;
      pend_r <= RESET_VAL;
    end else if (i_ce) begin
      rdata_r <= rdata_nxt;
      pend_r <= pend_nxt;
    end
  end

  // all outputs come from flip-flops
  assign o_rdata = rdata_r;
  assign o_flag_one = flag_one_q;
  assign o_flag_two = flag_two_q;
  assign o_flag_three = flag_three_q;
  assign o_flag_four = flag_four_q;
  assign o_en_zero = en_zero_q;
  assign o_pend_zero = pend_r;

endmodule

// *** rtl/irq_bank_pkg.sv ***
// constants of the interrupt flag and enable bank: register indices, field masks,
// bit positions, reset value.
// assumes a 16-bit register port on the system clock, word-indexed addresses.
//
// Overview of operation
// - flag bit shows request occurred, software R/W
// - enable bit allows matching request, software R/W
// - unimplemented bits ignore writes, read zero
// - all bits zero after reset
// - flag register two field positions
// - flag register three field positions
// - flag register four field positions
// - enable register zero bits 14 to 3
// - flag register one bits 2 to 0
// - no CAN controller disables CAN interrupts
// - no audio DAC disables DAC interrupts
// - enable register zero bits 2 to 0
package irq_bank_pkg;

  // register width and default address width
  localparam int DATA_W = 16;
  localparam int ADDR_W_DEF = 4;

  // register indices on the plain port
  localparam logic [3:0] OFS_FLAG_ONE = 4'h0;
  localparam logic [3:0] OFS_FLAG_TWO = 4'h1;
  localparam logic [3:0] OFS_FLAG_THREE = 4'h2;
  localparam logic [3:0] OFS_FLAG_FOUR = 4'h3;
  localparam logic [3:0] OFS_EN_ZERO = 4'h4;

  // value of every bit after reset
  localparam logic [15:0] RESET_VAL = 16'h0000;

  // flag register one positions
  localparam int BIT_COMPARATOR_REQ_FLAG = 2;
  localparam int BIT_I2C_MASTER_REQ_FLAG = 1;
  localparam int BIT_I2C_SLAVE_REQ_FLAG = 0;
  // flag register two positions
  localparam int BIT_DMA_CH4_DONE_FLAG = 14;
  localparam int BIT_PARALLEL_PORT_REQ_FLAG = 13;
  localparam int BIT_DMA_CH3_DONE_FLAG = 4;
  localparam int BIT_CAN_EVENT_FLAG = 3;
  localparam int BIT_CAN_RX_READY_FLAG = 2;
  localparam int BIT_SPI_TWO_EVENT_FLAG = 1;
  localparam int BIT_SPI_TWO_ERROR_FLAG = 0;
  // flag register three positions
  localparam int BIT_CALENDAR_REQ_FLAG = 14;
  localparam int BIT_DMA_CH5_DONE_FLAG = 13;
  localparam int BIT_AUDIO_IF_EVENT_FLAG = 12;
  localparam int BIT_AUDIO_IF_ERROR_FLAG = 11;
  // flag register four positions
  localparam int BIT_DAC_LEFT_FLAG = 15;
  localparam int BIT_DAC_RIGHT_FLAG = 14;
  localparam int BIT_CAN_TX_REQUEST_FLAG = 6;
  localparam int BIT_DMA_CH7_DONE_FLAG = 5;
  localparam int BIT_DMA_CH6_DONE_FLAG = 4;
  localparam int BIT_CHECKSUM_GEN_FLAG = 3;
  localparam int BIT_SERIAL_TWO_ERROR_FLAG = 2;
  localparam int BIT_SERIAL_ONE_ERROR_FLAG = 1;
  // enable register zero positions
  localparam int BIT_DMA_CH1_DONE_EN = 14;
  localparam int BIT_ADC_DONE_EN = 13;
  localparam int BIT_SERIAL_ONE_TX_EN = 12;
  localparam int BIT_SERIAL_ONE_RX_EN = 11;
  localparam int BIT_SPI_ONE_EVENT_EN = 10;
  localparam int BIT_SPI_ONE_ERROR_EN = 9;
  localparam int BIT_TIMER_THREE_EN = 8;
  localparam int BIT_TIMER_TWO_EN = 7;
  localparam int BIT_COMPARE_TWO_EN = 6;
  localparam int BIT_CAPTURE_TWO_EN = 5;
  localparam int BIT_DMA_CH0_DONE_EN = 4;
  localparam int BIT_TIMER_ONE_EN = 3;
  localparam int BIT_COMPARE_ONE_EN = 2;
  localparam int BIT_CAPTURE_ONE_EN = 1;
  localparam int BIT_EXT_IRQ_ZERO_EN = 0;

  // implemented-bit masks, one bit per field above
  localparam logic [15:0] MASK_FLAG_ONE = 16'h0007;
  localparam logic [15:0] MASK_FLAG_TWO = 16'h601f;
  localparam logic [15:0] MASK_FLAG_THREE = 16'h7800;
  localparam logic [15:0] MASK_FLAG_FOUR = 16'hc07e;
  localparam logic [15:0] MASK_EN_ZERO = 16'h7fff;

  // bits that vanish on variants without CAN or audio DAC
  localparam logic [15:0] CAN_BITS_TWO = 16'h000c;
  localparam logic [15:0] CAN_BITS_FOUR = 16'h0040;
  localparam logic [15:0] DAC_BITS_FOUR = 16'hc000;

endpackage

// *** rtl/flag_bank_reg.sv ***
// one 16-bit flag or enable register with per-bit implemented mask.
// assumes events and writes come from logic on the same clock.
`timescale 1ns/1ps
module flag_bank_reg #(
  parameter logic [15:0] IMPL_MASK = 16'hffff
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic i_wr,
  input wire logic [15:0] i_wdata,
  input wire logic [15:0] i_evt,
  output logic [15:0] o_q
);
  import irq_bank_pkg::*;

  logic [15:0] q_r; // stored bits
  logic [15:0] q_nxt; // next value

  // write loads the whole word, then events are or-ed on top so they win
  always_comb begin
    q_nxt = q_r;
    if (i_wr) begin
      q_nxt = i_wdata;
    end
    q_nxt = (q_nxt | i_evt) & IMPL_MASK;
  end

  // register only; clock enable freezes the word
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      q_r <= RESET_VAL;
    end else if (i_ce) begin
      q_r <= q_nxt;
    end
  end

  assign o_q = q_r;
endmodule

// *** test/irq_bank_checker.sv ***
// checker for the interrupt flag and enable bank, top-level ports only.
// assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
module irq_bank_checker
  import irq_bank_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic [15:0] i_evt_flag_two,
  input wire logic [15:0] i_evt_flag_three,
  input wire logic [15:0] i_flag_zero,
  input wire logic [15:0] o_flag_one,
  input wire logic [15:0] o_flag_two,
  input wire logic [15:0] o_flag_three,
  input wire logic [15:0] o_flag_four,
  input wire logic [15:0] o_en_zero,
  input wire logic [15:0] o_pend_zero
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  // register port requests, taken only with the clock enable high
  sequence s_rd_two;
    i_ce && i_rd && i_addr == ADDR_W'(OFS_FLAG_TWO);
  endsequence
  sequence s_rd_en;
    i_ce && i_rd && i_addr == ADDR_W'(OFS_EN_ZERO);
  endsequence
  sequence s_wr_en;
    i_ce && i_wr && i_addr == ADDR_W'(OFS_EN_ZERO);
  endsequence
  sequence s_clr_two;
    i_ce && i_wr && i_addr == ADDR_W'(OFS_FLAG_TWO) && i_wdata == 16'h0000;
  endsequence
  property p_rd_two;
    s_rd_two |=> o_rdata == $past(o_flag_two);
  endproperty
  a_rd_two: assert property (p_rd_two) else $error("flag two read word wrong");
  property p_rd_en;
    s_rd_en |=> o_rdata == $past(o_en_zero);
  endproperty
  a_rd_en: assert property (p_rd_en) else $error("enable read word wrong");
  property p_wr_en;
    s_wr_en |=> o_en_zero == ($past(i_wdata) & MASK_EN_ZERO);
  endproperty
  a_wr_en: assert property (p_wr_en) else $error("enable write not loaded");
  property p_evt_wins;
    s_clr_two ##0 i_evt_flag_two[14] |=> o_flag_two[14];
  endproperty
  a_evt_wins: assert property (p_evt_wins) else $error("clearing write beat event");
  // unimplemented positions of the four flag registers never hold a one
  property p_unimpl;
    ((o_flag_one & ~MASK_FLAG_ONE) | (o_flag_two & ~MASK_FLAG_TWO)
      | (o_flag_three & ~MASK_FLAG_THREE) | (o_flag_four & ~MASK_FLAG_FOUR)) == 16'h0000;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented flag bit set");
  property p_evt_set;
    i_ce |=> (o_flag_three & $past(i_evt_flag_three) & MASK_FLAG_THREE)
      == ($past(i_evt_flag_three) & MASK_FLAG_THREE);
  endproperty
  a_evt_set: assert property (p_evt_set) else $error("event did not set flag");
  // without a write flag register four only ever rises
  property p_hold;
    i_ce && !i_wr |=> ($past(o_flag_four) & ~o_flag_four) == 16'h0000;
  endproperty
  a_hold: assert property (p_hold) else $error("flag dropped without write");
  property p_pend;
    i_ce |=> o_pend_zero == ($past(i_flag_zero) & $past(o_en_zero));
  endproperty
  a_pend: assert property (p_pend) else $error("pending word wrong");
  // read data stand for one cycle only and are zero in every other enabled cycle
  property p_rd_idle;
    i_ce && !i_rd |=> o_rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stale read data");
endmodule

bind interrupt_flag_enable_bank irq_bank_checker #(.ADDR_W(ADDR_W)) irq_bank_checker_inst (
  .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_ce(i_ce), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_evt_flag_two(i_evt_flag_two), .i_evt_flag_three(i_evt_flag_three),
  .i_flag_zero(i_flag_zero), .o_flag_one(o_flag_one), .o_flag_two(o_flag_two),
  .o_flag_three(o_flag_three), .o_flag_four(o_flag_four), .o_en_zero(o_en_zero),
  .o_pend_zero(o_pend_zero));

// *** test/periph_model.sv ***
// peripheral side model: one-cycle event pulses and the level flag word.
// assumes its tasks are called from the bench on the system clock.
`timescale 1ns/1ps
module periph_model (
  input wire logic i_clk_sys,
  output logic [15:0] o_evt_flag_one,
  output logic [15:0] o_evt_flag_two,
  output logic [15:0] o_evt_flag_three,
  output logic [15:0] o_evt_flag_four,
  output logic [15:0] o_flag_zero
);
  logic [15:0] evt_r [4] = '{default: 16'h0000}; // pulse word per flag register
  logic [15:0] lvl_r = 16'h0000; // flags paired with enable zero
  assign o_evt_flag_one = evt_r[0];
  assign o_evt_flag_two = evt_r[1];
  assign o_evt_flag_three = evt_r[2];
  assign o_evt_flag_four = evt_r[3];
  assign o_flag_zero = lvl_r;
  // one-cycle pulse, dropped again so a flag is not re-set behind a clear
  task automatic pulse(input int r, input logic [15:0] b);
    @(posedge i_clk_sys);
    evt_r[r] <= b;
    @(posedge i_clk_sys);
    evt_r[r] <= 16'h0000;
  endtask
  task automatic level(input logic [15:0] v);
    @(posedge i_clk_sys);
    lvl_r <= v;
  endtask
endmodule

// *** test/tb.sv ***
// self-checking bench for the interrupt flag and enable bank.
// assumes periph_model drives the event side and the checker is bound to the top.
`timescale 1ns/1ps
module tb;
  import irq_bank_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_resetn = 1'b0;
  logic i_ce = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [15:0] o_rdata, o_pend_zero, evt1, evt2, evt3, evt4, lvl, rd_val;
  logic [15:0] o_rdata_lite, rd_lite; // answers of the variant without can and audio dac
  int bad_count = 0;
  int comparisons = 0;
  // implemented bits per index; the last index is unmapped
  logic [15:0] masks [6] = '{MASK_FLAG_ONE, MASK_FLAG_TWO, MASK_FLAG_THREE,
    MASK_FLAG_FOUR, MASK_EN_ZERO, 16'h0000};
  // same for the variant: can bits 3,2 of two and 6 of four, dac bits 15,14 of four gone
  logic [15:0] masks_lite [6] = '{16'h0007, 16'h6013, 16'h7800, 16'h003e, 16'h7fff, 16'h0000};
  always #2.5 i_clk_sys = ~i_clk_sys;
  periph_model periph_model_inst (.i_clk_sys(i_clk_sys), .o_evt_flag_one(evt1),
    .o_evt_flag_two(evt2), .o_evt_flag_three(evt3), .o_evt_flag_four(evt4), .o_flag_zero(lvl));
  interrupt_flag_enable_bank interrupt_flag_enable_bank_inst (.i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_evt_flag_one(evt1), .i_evt_flag_two(evt2),
    .i_evt_flag_three(evt3), .i_evt_flag_four(evt4), .i_flag_zero(lvl), .o_flag_one(),
    .o_flag_two(), .o_flag_three(), .o_flag_four(), .o_en_zero(), .o_pend_zero(o_pend_zero));
  // second build without can and audio dac, sharing the bus and event lines
  if (1) begin : g_lite
    interrupt_flag_enable_bank #(.HAS_CAN(1'b0), .HAS_DAC(1'b0)) interrupt_flag_enable_bank_inst (
      .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_ce(i_ce), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata_lite),
      .i_evt_flag_one(evt1), .i_evt_flag_two(evt2), .i_evt_flag_three(evt3),
      .i_evt_flag_four(evt4), .i_flag_zero(lvl), .o_flag_one(), .o_flag_two(),
      .o_flag_three(), .o_flag_four(), .o_en_zero(), .o_pend_zero());
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one-cycle strobes, launched just after an edge
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 rd_val = o_rdata;
    rd_lite = o_rdata_lite;
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    #20000;
    bad_count++;
    wrap_up();
  end
  initial begin
    repeat (10) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(4'(i));
      chk(rd_val, 16'h0000);
      wr(4'(i), 16'hffff);
      rd(4'(i));
      chk(rd_val, masks[i]);
      chk(rd_lite, masks_lite[i]);
      wr(4'(i), 16'h0000);
      rd(4'(i));
      chk(rd_val, 16'h0000);
    end
    // every source pulses, then software clears
    for (int i = 0; i < 4; i++) begin
      periph_model_inst.pulse(i, 16'hffff);
      rd(4'(i));
      chk(rd_val, masks[i]);
      chk(rd_lite, masks_lite[i]);
      wr(4'(i), 16'h0000);
    end
    // clearing write and event on one edge: the event must survive
    wr(4'h1, 16'h6000);
    fork
      wr(4'h1, 16'h0000);
      periph_model_inst.pulse(1, 16'h4000);
    join
    rd(4'h1);
    chk(rd_val, 16'h4000);
    // pending needs flag and enable, bit 15 has no enable
    wr(4'h4, 16'hffff);
    periph_model_inst.level(16'h8001);
    repeat (2) @(posedge i_clk_sys);
    #1 chk(o_pend_zero, 16'h0001);
    wr(4'h4, 16'h0000);
    repeat (2) @(posedge i_clk_sys);
    #1 chk(o_pend_zero, 16'h0000);
    // strobes are ignored while the clock enable is low
    @(posedge i_clk_sys);
    i_ce <= 1'b0;
    wr(4'h4, 16'h1234);
    i_ce <= 1'b1;
    rd(4'h4);
    chk(rd_val, 16'h0000);
    // reset in mid-run clears the flag left by the event test and the enables
    wr(4'h4, 16'hffff);
    @(posedge i_clk_sys);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    rd(4'h1);
    chk(rd_val, 16'h0000);
    rd(4'h4);
    chk(rd_val, 16'h0000);
    wrap_up();
  end
endmodule
